/* File: core/supply_clock_ctrl.sv */
// Operation
// - Power-on monitors always active on both rails
// - I/O brownout always; core only with regulator
// - Any rail below threshold holds reset low
// - Core overvoltage asserts reset with regulator
// - Reset released after fixed delay once clear
// - Power-on threshold below brownout threshold
// - One bit disables both brownout functions
// - Protected registers written only while permitted
// - Both internal oscillators on at power-up
// - Oscillator one is default clock source
// - Software may power down unused oscillators
// - Each oscillator trimmed by own trim register
// - System clock out equals processor clock
// - PLL registers reset only by pin/watchdog; here aresetn also clears them
//
// Design decision made here: the AXI4-Lite interface to the registers.
`default_nettype none
module supply_clock_ctrl
   import supply_clock_pkg::*;
#(
   parameter int RELEASE_COUNT = RELEASE_CYCLES
) (
   input  wire logic                          aclk,
   input  wire logic                          aresetn,
   input  wire logic                          awvalid,
   output logic                               awready,
   input  wire logic [19:0]                   awaddr,
   input  wire logic                          wvalid,
   output logic                               wready,
   input  wire logic [31:0]                   wdata,
   input  wire logic [3:0]                    wstrb,
   output logic                               bvalid,
   input  wire logic                          bready,
   output logic [1:0]                         bresp,
   input  wire logic                          arvalid,
   output logic                               arready,
   input  wire logic [19:0]                   araddr,
   output logic                               rvalid,
   input  wire logic                          rready,
   output logic [31:0]                        rdata,
   output logic [1:0]                         rresp,
   input  wire supply_clock_pkg::supply_flags_s supply_flags,
   input  wire logic                          regulator_enable_n,
   input  wire logic                          watchdog_reset,
   input  wire logic                          ext_reset_n,
   input  wire logic                          debug_reset,
   input  wire logic                          cpu_input_clock,
   input  wire logic [15:0]                   watchdog_count_in,
   output logic                               system_reset_pin_n,
   output logic                               supply_monitor_reset,
   output logic                               system_reset,
   output logic                               system_clock_out,
   output supply_clock_pkg::osc_ctrl_s        osc_ctrl
);
   import supply_clock_pkg::*;

   // Map a word index to a storage slot; slot 15 means no storage (unmapped index or the watchdog key)
   function automatic logic [3:0] slot_of(input logic [15:0] idx);
      unique case (idx)
         IDX_BROWNOUT_CONFIG:   slot_of = 4'h0;
         IDX_CLOCK_OUTPUT_CTRL: slot_of = 4'h1;
         IDX_PLL_STATE:         slot_of = 4'h2;
         IDX_CLOCK_SOURCE_CTRL: slot_of = 4'h3;
         IDX_PLL_LOCK_PERIOD:   slot_of = 4'h4;
         IDX_OSC_ONE_TRIM:      slot_of = 4'h5;
         IDX_OSC_TWO_TRIM:      slot_of = 4'h6;
         IDX_SLOW_PRESCALER:    slot_of = 4'h7;
         IDX_PCLK_GATE_0:       slot_of = 4'h8;
         IDX_PCLK_GATE_1:       slot_of = 4'h9;
         IDX_LOW_POWER_CTRL:    slot_of = 4'hA;
         IDX_PCLK_GATE_3:       slot_of = 4'hB;
         IDX_PLL_MULT_CTRL:     slot_of = 4'hC;
         IDX_SYS_CTRL_STATUS:   slot_of = 4'hD;
         IDX_PCLK_GATE_4:       slot_of = 4'hE;
         IDX_WATCHDOG_KEY:      slot_of = 4'hF;
         default:               slot_of = 4'hF;
      endcase
   endfunction

   // Slot numbers of the brownout, PLL, clock source and trim registers (used below)
   localparam logic [3:0] SLOT_BROWNOUT = 4'h0;
   localparam logic [3:0] SLOT_PLL_ST   = 4'h2;
   localparam logic [3:0] SLOT_CLK_SRC  = 4'h3;
   localparam logic [3:0] SLOT_TRIM_1   = 4'h5;
   localparam logic [3:0] SLOT_TRIM_2   = 4'h6;
   localparam logic [3:0] SLOT_PLL_MUL  = 4'hC;

   // Register storage
   logic [15:0]   regs_q [NUM_REGS];      // General registers
   logic [15:0]   wd_ctrl_q;              // Watchdog control
   logic          permit_q;               // Protected write permit
   logic          pin_or_wd_q;            // Pending PLL-register reset

   // Write channel holding registers
   logic          aw_full_q;              // Address captured
   logic [15:0]   aw_idx_q;               // Captured word index
   logic          w_full_q;               // Data captured
   logic [15:0]   w_data_q;               // Captured low half-word
   logic          w_lane_q;               // Low lanes enabled
   logic          bvalid_q;               // Write response pending
   logic [1:0]    bresp_q;                // Write response code
   logic          rvalid_q;               // Read data pending
   logic [31:0]   rdata_q;                // Read data
   logic [1:0]    rresp_q;                // Read response code

   // Supply monitor state
   reset_state_e  rst_state_q;            // Release sequencer state
   logic [31:0]   delay_q;                // Release delay counter

   // Decoded write target
   wire  [3:0]    wr_slot   = slot_of(aw_idx_q);
   wire           wr_is_wd  = (aw_idx_q == IDX_WATCHDOG_CTRL);
   wire           wr_is_pm  = (aw_idx_q == IDX_WRITE_PERMIT);
   wire           wr_is_map = (wr_slot != 4'hF) ||
                              (aw_idx_q == IDX_WATCHDOG_KEY) || wr_is_wd;
   wire           wr_go     = aw_full_q && w_full_q && !bvalid_q;
   wire           wr_allow  = permit_q && w_lane_q;

   // Decoded read target
   wire  [15:0]   rd_idx    = araddr[17:2];
   wire  [3:0]    rd_slot   = slot_of(rd_idx);
   wire           rd_is_wd  = (rd_idx == IDX_WATCHDOG_CTRL);
   wire           rd_is_cnt = (rd_idx == IDX_WATCHDOG_COUNT);
   wire           rd_is_pm  = (rd_idx == IDX_WRITE_PERMIT);
   wire           rd_is_map = (rd_slot != 4'hF) ||
                              (rd_idx == IDX_WATCHDOG_KEY) ||
                              rd_is_wd || rd_is_cnt || rd_is_pm;
   wire           rd_go     = arvalid && !rvalid_q;

   // Supply monitor terms
   wire           bo_disable = regs_q[SLOT_BROWNOUT][BO_DISABLE_BIT];
   wire           por_trip  = supply_flags.core_por || supply_flags.io_por;
   wire           bo_trip   = !bo_disable && (supply_flags.io_bo ||
                              (!regulator_enable_n && supply_flags.core_bo));
   wire           ov_trip   = !regulator_enable_n && supply_flags.core_ov;
   wire           fault     = por_trip || bo_trip || ov_trip;
   wire           delay_end = (delay_q >= 32'(RELEASE_COUNT - 1));

   // Bus handshakes
   assign awready = !aw_full_q;
   assign wready  = !w_full_q;
   assign arready = !rvalid_q;
   assign bvalid  = bvalid_q;
   assign bresp   = bresp_q;
   assign rvalid  = rvalid_q;
   assign rdata   = rdata_q;
   assign rresp   = rresp_q;

   // Write address capture
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_full_q <= 1'b0;
         aw_idx_q  <= RST_ZERO;
      end else if (awvalid && awready) begin
         aw_full_q <= 1'b1;
         aw_idx_q  <= awaddr[17:2];
      end else if (wr_go) begin
         aw_full_q <= 1'b0;
      end
   end

   // Write data capture
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         w_full_q <= 1'b0;
         w_data_q <= RST_ZERO;
         w_lane_q <= 1'b0;
      end else if (wvalid && wready) begin
         w_full_q <= 1'b1;
         w_data_q <= wdata[15:0];
         w_lane_q <= &wstrb[1:0];
      end else if (wr_go) begin
         w_full_q <= 1'b0;
      end
   end

   // Write response
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         bvalid_q <= 1'b0;
         bresp_q  <= RESP_OKAY;
      end else if (wr_go) begin
         bvalid_q <= 1'b1;
         bresp_q  <= (wr_is_map || wr_is_pm) ? RESP_OKAY : RESP_SLVERR;
      end else if (bready) begin
         bvalid_q <= 1'b0;
      end
   end

   // Permit register, written without protection
   always_ff @(posedge aclk) begin
      if (!aresetn)
         permit_q <= 1'b0;
      else if (wr_go && wr_is_pm && w_lane_q)
         permit_q <= w_data_q[PERMIT_BIT];
   end

   // PLL registers reset by pin, watchdog or aresetn (aresetn loads the pending flag)
   always_ff @(posedge aclk) begin
      if (!aresetn)
         pin_or_wd_q <= 1'b1;
      else
         pin_or_wd_q <= !ext_reset_n || watchdog_reset;
   end

   // General register file with protected writes
   genvar g;
   generate
      for (g = 0; g < NUM_REGS; g++) begin : g_reg
         localparam logic [3:0] SLOT = 4'(g);
         localparam logic       IS_PLL = (SLOT == SLOT_PLL_ST) ||
                                         (SLOT == SLOT_PLL_MUL);
         // Reset word per slot: clock source and trims have their own
         localparam logic [15:0] RST_VAL =
            (SLOT == SLOT_CLK_SRC) ? RST_CLOCK_SOURCE :
            ((SLOT == SLOT_TRIM_1) || (SLOT == SLOT_TRIM_2)) ? RST_TRIM :
            RST_ZERO;
         always_ff @(posedge aclk) begin
            if (!aresetn && !IS_PLL) begin
               regs_q[g] <= RST_VAL;
            end else if (IS_PLL && pin_or_wd_q) begin
               regs_q[g] <= RST_ZERO;
            end else if (wr_go && wr_allow && wr_slot == SLOT &&
                         SLOT != 4'hF) begin
               regs_q[g] <= w_data_q;
            end
         end
      end
   endgenerate

   // Watchdog control, also protected
   always_ff @(posedge aclk) begin
      if (!aresetn)
         wd_ctrl_q <= RST_ZERO;
      else if (wr_go && wr_allow && wr_is_wd)
         wd_ctrl_q <= w_data_q;
   end

   // Read path
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rvalid_q <= 1'b0;
         rdata_q  <= 32'h0000_0000;
         rresp_q  <= RESP_OKAY;
      end else if (rd_go) begin
         rvalid_q <= 1'b1;
         rresp_q  <= rd_is_map ? RESP_OKAY : RESP_SLVERR;
         if (rd_is_cnt)
            rdata_q <= {16'h0000, watchdog_count_in};
         else if (rd_is_wd)
            rdata_q <= {16'h0000, wd_ctrl_q};
         else if (rd_is_pm)
            rdata_q <= {31'h0, permit_q};
         else if (rd_slot != 4'hF)
            rdata_q <= {16'h0000, regs_q[rd_slot]};
         else
            rdata_q <= 32'h0000_0000;
      end else if (rready) begin
         rvalid_q <= 1'b0;
      end
   end

   // Reset release sequencer
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rst_state_q <= RST_HELD;
         delay_q     <= 32'h0000_0000;
      end else if (fault) begin
         rst_state_q <= RST_HELD;
         delay_q     <= 32'h0000_0000;
      end else begin
         unique case (rst_state_q)
            RST_HELD: begin
               rst_state_q <= RST_COUNT;
               delay_q     <= 32'h0000_0000;
            end
            RST_COUNT: begin
               if (delay_end)
                  rst_state_q <= RST_RELEASE;
               else
                  delay_q <= delay_q + 32'h1;
            end
            RST_RELEASE: rst_state_q <= RST_RELEASE;
            default:     rst_state_q <= RST_HELD;
         endcase
      end
   end

   assign supply_monitor_reset = (rst_state_q != RST_RELEASE);
   assign system_reset_pin_n   = !supply_monitor_reset;
   assign system_reset = watchdog_reset || supply_monitor_reset ||
                         !ext_reset_n;
   assign system_clock_out = cpu_input_clock;

   // Oscillator controls from clock source and trim registers
   // enables are inverted off bits
   assign osc_ctrl.osc_one_en = !regs_q[SLOT_CLK_SRC][OSC_ONE_OFF_BIT];
   assign osc_ctrl.osc_two_en = !regs_q[SLOT_CLK_SRC][OSC_TWO_OFF_BIT];
   assign osc_ctrl.source   = regs_q[SLOT_CLK_SRC][SRC_SEL_LSB +: 2];
   assign osc_ctrl.trim_one = regs_q[SLOT_TRIM_1];
   assign osc_ctrl.trim_two = regs_q[SLOT_TRIM_2];

   // Fault forces the reset pin low from the next cycle
   AST_FAULT_HOLDS: assert property (
      @(posedge aclk) disable iff (!aresetn)
      fault |=> !system_reset_pin_n)
      else $error("reset pin not held during fault");
   // Overvoltage honoured only with regulator on
   AST_OV_TRIP: assert property (
      @(posedge aclk) disable iff (!aresetn)
      (supply_flags.core_ov && !regulator_enable_n)
      |=> supply_monitor_reset)
      else $error("overvoltage ignored");
   // Release never sooner than the delay after clearing
   AST_DELAY: assert property (
      @(posedge aclk) disable iff (!aresetn)
      $rose(system_reset_pin_n) |-> delay_q == 32'(RELEASE_COUNT - 1))
      else $error("reset released early");
   // Once released, the pin stays high until a fault returns
   AST_RELEASE_HOLDS: assert property (
      @(posedge aclk) disable iff (!aresetn)
      (system_reset_pin_n && !fault) |=> system_reset_pin_n)
      else $error("reset pin dropped without fault");
   // Brownout disable bit suppresses both brownouts
   AST_BO_OFF: assert property (
      @(posedge aclk) disable iff (!aresetn)
      (bo_disable && !por_trip && !ov_trip) |-> !fault)
      else $error("brownout not disabled");
   // I/O power-on trip always honoured
   AST_POR: assert property (
      @(posedge aclk) disable iff (!aresetn)
      supply_flags.io_por |=> supply_monitor_reset)
      else $error("power-on trip ignored");
   // Writes without permit leave the source control unchanged
   AST_PERMIT: assert property (
      @(posedge aclk) disable iff (!aresetn)
      (wr_go && !permit_q && wr_slot == SLOT_CLK_SRC)
      |=> $stable(osc_ctrl.source))
      else $error("protected write accepted");
   // System reset follows the watchdog and pin sources
   AST_SYSRST: assert property (
      @(posedge aclk) disable iff (!aresetn)
      (watchdog_reset || !ext_reset_n) |-> system_reset)
      else $error("system reset missing");
   // Core brownout needs the regulator enabled
   AST_CORE_BO: assert property (
      @(posedge aclk) disable iff (!aresetn)
      (supply_flags.core_bo && regulator_enable_n && !supply_flags.io_bo
       && !por_trip && !ov_trip) |-> !fault)
      else $error("core brownout without regulator");
   // Pin or watchdog reset clears both PLL words two edges later
   AST_PLL_CLEAR: assert property (
      @(posedge aclk) disable iff (!aresetn)
      (!ext_reset_n || watchdog_reset) |-> ##2
      (regs_q[SLOT_PLL_MUL] == RST_ZERO && regs_q[SLOT_PLL_ST] == RST_ZERO))
      else $error("pll words not cleared by pin or watchdog");
   // Debugger reset alone leaves the PLL control word alone
   AST_DEBUG_KEEPS: assert property (
      @(posedge aclk) disable iff (!aresetn)
      (debug_reset && !pin_or_wd_q && !wr_go)
      |=> $stable(regs_q[SLOT_PLL_MUL]))
      else $error("debug reset cleared pll control");
   // Oscillators both on and oscillator one selected out of reset
   AST_OSC_DEFAULT: assert property (
      @(posedge aclk) disable iff (!aresetn)
      $rose(aresetn) |-> (osc_ctrl.osc_one_en && osc_ctrl.osc_two_en &&
                          osc_ctrl.source == SRC_OSC_ONE))
      else $error("oscillator defaults wrong after reset");
endmodule
`default_nettype wire

/* File: pkg/supply_clock_pkg.sv */
`default_nettype none
package supply_clock_pkg;
   // Register indices (word index; byte address is four times this)
   localparam logic [15:0] IDX_BROWNOUT_CONFIG    = 16'h0985;
   localparam logic [15:0] IDX_CLOCK_OUTPUT_CTRL  = 16'h7010;
   localparam logic [15:0] IDX_PLL_STATE          = 16'h7011;
   localparam logic [15:0] IDX_CLOCK_SOURCE_CTRL  = 16'h7012;
   localparam logic [15:0] IDX_PLL_LOCK_PERIOD    = 16'h7013;
   localparam logic [15:0] IDX_OSC_ONE_TRIM       = 16'h7014;
   localparam logic [15:0] IDX_OSC_TWO_TRIM       = 16'h7016;
   localparam logic [15:0] IDX_SLOW_PRESCALER     = 16'h701B;
   localparam logic [15:0] IDX_PCLK_GATE_0        = 16'h701C;
   localparam logic [15:0] IDX_PCLK_GATE_1        = 16'h701D;
   localparam logic [15:0] IDX_LOW_POWER_CTRL     = 16'h701E;
   localparam logic [15:0] IDX_PCLK_GATE_3        = 16'h7020;
   localparam logic [15:0] IDX_PLL_MULT_CTRL      = 16'h7021;
   localparam logic [15:0] IDX_SYS_CTRL_STATUS    = 16'h7022;
   localparam logic [15:0] IDX_WATCHDOG_COUNT     = 16'h7023;
   localparam logic [15:0] IDX_PCLK_GATE_4        = 16'h7024;
   localparam logic [15:0] IDX_WATCHDOG_KEY       = 16'h7025;
   localparam logic [15:0] IDX_WATCHDOG_CTRL      = 16'h7029;
   // Own register: protected write permit (bit 0)
   localparam logic [15:0] IDX_WRITE_PERMIT       = 16'h7030;
   // Number of 16-bit storage registers (indices 0..15)
   localparam int          NUM_REGS               = 16;
   // Field positions
   localparam int          BO_DISABLE_BIT         = 0;
   localparam int          OSC_ONE_OFF_BIT        = 0;
   localparam int          OSC_TWO_OFF_BIT        = 1;
   localparam int          SRC_SEL_LSB            = 2;
   localparam int          PERMIT_BIT             = 0;
   localparam int          TRIM_LSB               = 0;
   // Reset values
   localparam logic [15:0] RST_ZERO               = 16'h0000;
   localparam logic [15:0] RST_CLOCK_SOURCE       = 16'h0000;
   localparam logic [15:0] RST_TRIM               = 16'h0000;
   // Clock source select codes
   localparam logic [1:0]  SRC_OSC_ONE            = 2'h0;
   localparam logic [1:0]  SRC_OSC_TWO            = 2'h1;
   localparam logic [1:0]  SRC_CRYSTAL            = 2'h2;
   localparam logic [1:0]  SRC_EXTERNAL           = 2'h3;
   // Reset release delay
   localparam int          CLK_PERIOD_NS          = 10;
   localparam int          RELEASE_DELAY_US       = 800;
   localparam int          RELEASE_CYCLES         =
      (RELEASE_DELAY_US * 1000) / CLK_PERIOD_NS;
   localparam logic [1:0]  RESP_OKAY              = 2'h0;
   localparam logic [1:0]  RESP_SLVERR            = 2'h2;
   // Supply detector flags
   typedef struct packed {
      logic core_por;  // Core rail below power-on level
      logic io_por;    // I/O rail below power-on level
      logic core_bo;   // Core rail below brownout level
      logic io_bo;     // I/O rail below brownout level
      logic core_ov;   // Core rail above overvoltage level
   } supply_flags_s;
   // Oscillator control bundle
   typedef struct packed {
      logic        osc_one_en;  // Oscillator one powered
      logic        osc_two_en;  // Oscillator two powered
      logic [1:0]  source;      // Selected system clock source
      logic [15:0] trim_one;    // Trim of oscillator one
      logic [15:0] trim_two;    // Trim of oscillator two
   } osc_ctrl_s;
   typedef enum logic [1:0] {
      RST_HELD    = 2'b00,
      RST_COUNT   = 2'b01,
      RST_RELEASE = 2'b10
   } reset_state_e;
endpackage
`default_nettype wire

/* File: verification/supply_rail_model.sv */
`default_nettype none
// Rails and board reset line seen from the device's pins
module supply_rail_model #(
   parameter logic [7:0] POR_TRIP = 8'h40,
   parameter logic [7:0] BO_TRIP  = 8'h60,
   parameter logic [7:0] OV_TRIP  = 8'hD0
) (
   input  wire logic [7:0]              io_level,
   input  wire logic                    board_reset,
   input  wire logic [7:0]              core_lv,
   output supply_clock_pkg::supply_flags_s supply_flags,
   output logic                         ext_reset_n
);
   timeunit 1ns;
   timeprecision 1ps;
   import supply_clock_pkg::*;
   assign supply_flags.core_por = core_lv < POR_TRIP;
   assign supply_flags.io_por   = io_level < POR_TRIP;
   assign supply_flags.core_bo  = core_lv < BO_TRIP;
   assign supply_flags.io_bo    = io_level < BO_TRIP;
   assign supply_flags.core_ov  = core_lv > OV_TRIP;
   // Board line has a pull-up, so it idles high
   assign ext_reset_n = board_reset ? 1'b0 : 1'b1;
endmodule
`default_nettype wire

/* File: verification/supply_reset_and_clock_source_control_tb.sv */
`default_nettype none
module supply_reset_and_clock_source_control_tb;
   timeunit 1ns;
   timeprecision 1ps;
   import supply_clock_pkg::*;
   localparam int REL = 8;
   logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
   logic awready, wready, bvalid, arready, rvalid;
   logic [19:0] awaddr, araddr;
   logic [31:0] wdata, rdata, rd;
   logic [3:0]  wstrb;
   logic [1:0]  bresp, rresp, resp;
   logic pin_n, mon_rst, sys_rst, clk_out, ext_n;
   logic reg_n, wdog, dbg, cpu_clk, board_rst, rn, bd, ex;
   logic [15:0] wd_cnt;
   logic [7:0]  core_lv, io_lv, lc, li;
   osc_ctrl_s     osc;
   supply_flags_s flags;
   int n_errors, num_checks, cyc;
   // Case table: core level, io level, regulator_n, bo off, reset
   logic [18:0] tbl [9] = '{
      {8'h50, 8'h80, 3'b001}, {8'h50, 8'h80, 3'b100},
      {8'h80, 8'h50, 3'b001}, {8'h80, 8'h50, 3'b010},
      {8'h50, 8'h80, 3'b010}, {8'h30, 8'h80, 3'b011},
      {8'h80, 8'h30, 3'b011}, {8'hE0, 8'h80, 3'b001},
      {8'hE0, 8'h80, 3'b100}};

   supply_rail_model rails (
      .io_level     (io_lv),
      .board_reset  (board_rst),
      .core_lv      (core_lv),
      .supply_flags (flags),
      .ext_reset_n  (ext_n)
   );
   supply_clock_ctrl #(.RELEASE_COUNT(REL)) dut (
      .aclk(aclk), .aresetn(aresetn), .awvalid(awvalid),
      .awready(awready), .awaddr(awaddr), .wvalid(wvalid),
      .wready(wready), .wdata(wdata), .wstrb(wstrb), .bvalid(bvalid),
      .bready(bready), .bresp(bresp), .arvalid(arvalid),
      .arready(arready), .araddr(araddr), .rvalid(rvalid),
      .rready(rready), .rdata(rdata), .rresp(rresp),
      .supply_flags(flags), .regulator_enable_n(reg_n),
      .watchdog_reset(wdog), .ext_reset_n(ext_n), .debug_reset(dbg),
      .cpu_input_clock(cpu_clk), .watchdog_count_in(wd_cnt),
      .system_reset_pin_n(pin_n), .supply_monitor_reset(mon_rst),
      .system_reset(sys_rst), .system_clock_out(clk_out),
      .osc_ctrl(osc)
   );
   // Free-running 100 MHz clock
   initial begin
      aclk = 1'b0;
      forever #5 aclk = ~aclk;
   end
   // Compare and count
   task check(input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         n_errors++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task print_verdict;
      $display("checks=%0d errors=%0d", num_checks, n_errors);
      if (n_errors == 0 && num_checks > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask
   // Bus write: handshakes taken at the rising edge, released there
   task wr(input logic [15:0] idx, input logic [15:0] d);
      logic a, w, b;
      awaddr <= {2'b00, idx, 2'b00};
      wdata <= {16'h0000, d};
      wstrb <= 4'hF;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      b = 1'b0;
      while (!b) begin
         @(posedge aclk);
         a = awvalid & awready;
         w = wvalid & wready;
         b = bvalid;
         resp = bresp;
         if (a) awvalid <= 1'b0;
         if (w) wvalid <= 1'b0;
      end
      bready <= 1'b0;
      // Let an edge pass so bready is low at one edge before a following call re-drives it
      @(posedge aclk);
   endtask
   // Bus read: data and response taken at the edge rvalid is seen
   task rd_reg(input logic [15:0] idx);
      logic a, r;
      araddr <= {2'b00, idx, 2'b00};
      arvalid <= 1'b1;
      rready <= 1'b1;
      r = 1'b0;
      while (!r) begin
         @(posedge aclk);
         a = arvalid & arready;
         r = rvalid;
         rd = rdata;
         resp = rresp;
         if (a) arvalid <= 1'b0;
      end
      rready <= 1'b0;
      @(posedge aclk);
   endtask
   // Bounded wait for the reset pin level
   task wait_pin(input logic v, input int n);
      for (int i = 0; i < n && pin_n !== v; i++) @(negedge aclk);
      check(pin_n, v);
      @(posedge aclk);
   endtask
   // Hang guard
   always @(posedge aclk) begin
      cyc <= cyc + 1;
      if (cyc == 4000) begin
         n_errors++;
         print_verdict();
      end
   end
   initial begin
      {aresetn, awvalid, wvalid, bready, arvalid, rready} = '0;
      {awaddr, araddr, wdata, wstrb, wdog, dbg, cpu_clk, reg_n} = '0;
      core_lv = 8'h80;
      io_lv = 8'h80;
      board_rst = 1'b1;
      wd_cnt = 16'h5A5A;
      n_errors = 0;
      num_checks = 0;
      cyc = 0;
      repeat (3) @(posedge aclk);
      aresetn <= 1'b1;
      board_rst <= 1'b0;
      @(negedge aclk);
      check(osc[35:32], {1'b1, 1'b1, SRC_OSC_ONE});
      check(osc[31:0], {RST_TRIM, RST_TRIM});
      repeat (REL) @(negedge aclk);
      check(pin_n, 1'b0);
      wait_pin(1'b1, 6);
      $display("reset values done");
      wr(IDX_CLOCK_SOURCE_CTRL, 16'h0005);
      rd_reg(IDX_CLOCK_SOURCE_CTRL);
      check(rd, 32'h0);
      check(resp, RESP_OKAY);
      wr(IDX_WRITE_PERMIT, 16'h0001);
      wr(IDX_CLOCK_SOURCE_CTRL, 16'h0005);
      check(osc[35:32], {2'b01, SRC_OSC_TWO});
      wr(IDX_OSC_ONE_TRIM, 16'h1234);
      wr(IDX_OSC_TWO_TRIM, 16'hABCD);
      check(resp, RESP_OKAY);
      check(osc[31:0], 32'h1234ABCD);
      rd_reg(16'h7031);
      check(rd, 32'h0);
      check(resp, RESP_SLVERR);
      wr(16'h7031, 16'h0001);
      check(resp, RESP_SLVERR);
      rd_reg(IDX_WATCHDOG_COUNT);
      check(rd, 32'h5A5A);
      $display("registers done");
      wr(IDX_PLL_MULT_CTRL, 16'h0005);
      dbg <= 1'b1;
      repeat (2) @(posedge aclk);
      dbg <= 1'b0;
      rd_reg(IDX_PLL_MULT_CTRL);
      check(rd, 32'h5);
      board_rst <= 1'b1;
      @(negedge aclk);
      check(sys_rst, 1'b1);
      @(posedge aclk);
      board_rst <= 1'b0;
      repeat (2) @(posedge aclk);
      rd_reg(IDX_PLL_MULT_CTRL);
      check(rd, 32'h0);
      wr(IDX_PLL_MULT_CTRL, 16'h0005);
      wdog <= 1'b1;
      @(negedge aclk);
      check(sys_rst, 1'b1);
      @(posedge aclk);
      wdog <= 1'b0;
      repeat (2) @(posedge aclk);
      rd_reg(IDX_PLL_MULT_CTRL);
      check(rd, 32'h0);
      for (int k = 0; k < 2; k++) begin
         cpu_clk <= ~cpu_clk;
         @(negedge aclk);
         check(clk_out, cpu_clk);
         @(posedge aclk);
      end
      $display("pll and clock done");
      for (int i = 0; i < 9; i++) begin
         {lc, li, rn, bd, ex} = tbl[i];
         wr(IDX_BROWNOUT_CONFIG, {15'h0, bd});
         reg_n <= rn;
         core_lv <= lc;
         io_lv <= li;
         repeat (4) @(negedge aclk);
         check(pin_n, !ex);
         check({mon_rst, sys_rst}, {ex, ex});
         @(posedge aclk);
         core_lv <= 8'h80;
         io_lv <= 8'h80;
         if (ex) begin
            repeat (REL - 2) @(negedge aclk);
            check(pin_n, 1'b0);
            @(posedge aclk);
         end
         wait_pin(1'b1, REL + 6);
      end
      $display("supply cases done");
      print_verdict();
   end
endmodule
`default_nettype wire
